// [spf_regs.svh]
// Register offsets, field positions, reset values and timing counts of the self-program flash control
`ifndef SPF_REGS_SVH
`define SPF_REGS_SVH

`define SPF_CTRL_IDX        10'h037
`define SPF_CTRL_ADDR       {`SPF_CTRL_IDX, 2'b00}
`define SPF_CTRL_RESET      5'h00
`define SPF_CTRL_W          5
`define SPF_BIT_STORE_EN    0
`define SPF_BIT_CLEAR_BUF   4

`define SPF_CODE_FILL       5'h01
`define SPF_CODE_ERASE      5'h03
`define SPF_CODE_WRITE      5'h05
`define SPF_CODE_RDCFG      5'h09
`define SPF_CODE_CLRBUF     5'h11

`define SPF_STORE_WIN       3'h4
`define SPF_LOAD_WIN        3'h3

`define SPF_CFG_FUSE_LOW    2'h0
`define SPF_CFG_LOCK        2'h1
`define SPF_CFG_FUSE_EXT    2'h2
`define SPF_CFG_FUSE_HIGH   2'h3
`define SPF_LOCK_UNUSED     6'h3F

`define SPF_BUF_ERASED      16'hFFFF
`define SPF_PIN_RESET       27'h7FFFFFF

`define SPF_CLK_PERIOD_NS   5
`define SPF_FLASH_MIN_NS    3700000
`define SPF_FLASH_MAX_NS    4500000
`define SPF_FLASH_CYCLES    ((`SPF_FLASH_MIN_NS + `SPF_CLK_PERIOD_NS - 1) / `SPF_CLK_PERIOD_NS)

`endif

// [spf_pkg.sv]
// Types shared by the self-program flash control
`default_nettype none
package spf_pkg;

  typedef enum logic [1:0] {
    SPF_OP_IDLE,
    SPF_OP_ERASE,
    SPF_OP_WRITE
  } spf_op_e;

  typedef struct packed {
    logic        store;
    logic        load;
    logic [15:0] pointer;
    logic [15:0] pair;
  } spf_core_req_s;

  typedef struct packed {
    spf_op_e     op;
    logic [15:0] page_ptr;
  } spf_flash_cmd_s;

endpackage
`default_nettype wire

// [spf_ctrl.sv]
// Self-program flash control: command register, arming windows, page buffer and flash timing
//
// How it works
// - Armed config read returns config bits on load
// - Config arming clears on read or timeout
// - Disarmed loads return normal flash data
// - Pointer one returns both lock bits
// - Pointer zero returns the low fuse byte
// - Pointer three high fuse, two extended
// - Flash operations last 3.7 to 4.5 ms
// - Running flash operation survives system reset
// - Control bits 7:5 always read zero
// - Clear-buffer code empties the page buffer
// - Two lowest pointer bits pick lock or fuse
// - Armed page write writes buffer to page
// - Page write bit self-clears, core stalled meanwhile
// - Armed page erase erases addressed page
// - Page erase bit self-clears, core stalled meanwhile
// - Plain store fills one buffer word
// - Store enable clears after store or timeout
// - Only five codes arm, others ignored
// - EEPROM write blocks programming and config reads
// - Buffer erased after page write and reset, except a system reset during a page erase
// - Programmed bits read zero, unprogrammed one
`include "spf_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module spf_ctrl #(
  parameter int PAGE_WORDS   = 32,
  parameter int WRITE_CYCLES = `SPF_FLASH_CYCLES
) (
  input  wire logic                    CLK,
  input  wire logic                    RESET_N,
  input  wire logic                    PWR_RESET_N,
  input  wire logic                    CE,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [11:0]             PADDR,
  input  wire logic [31:0]             PWDATA,
  input  wire logic [3:0]              PSTRB,
  output var  logic [31:0]             PRDATA,
  output var  logic                    PREADY,
  output var  logic                    PSLVERR,
  input  wire spf_pkg::spf_core_req_s  CORE_REQ,
  output var  logic                    CORE_STALL,
  output var  logic                    LOAD_CFG_VALID,
  output var  logic [7:0]              LOAD_CFG_DATA,
  input  wire logic [1:0]              LOCK_BITS,
  input  wire logic [7:0]              FUSE_LOW,
  input  wire logic [7:0]              FUSE_HIGH,
  input  wire logic [7:0]              FUSE_EXT,
  input  wire logic                    EEPROM_WRITE_BUSY,
  output var  spf_pkg::spf_flash_cmd_s FLASH_CMD,
  input  wire logic [$clog2(PAGE_WORDS)-1:0] FLASH_BUF_IDX,
  output var  logic [15:0]             FLASH_BUF_DATA
);
  import spf_pkg::*;

  localparam int WB   = $clog2(PAGE_WORDS);
  localparam int TIMW = $clog2(WRITE_CYCLES + 1);

  logic                      rst_meta_reg;
  logic                      rst_n_reg;
  logic                      por_meta_reg;
  logic                      por_n_reg;
  logic [26:0]               pin_meta_reg;
  logic [26:0]               pin_reg;
  logic                      eep_prev_reg;
  logic                      pready_reg;
  logic                      pslverr_reg;
  logic [31:0]               prdata_reg;
  logic [`SPF_CTRL_W-1:0]    ctrl_reg;
  logic [2:0]                elapsed_reg;
  spf_op_e                   op_state_reg;
  logic [TIMW-1:0]           timer_reg;
  logic [15:0]               op_ptr_reg;
  logic                      stall_reg;
  logic                      load_valid_reg;
  logic [7:0]                load_data_reg;
  logic [15:0]               buf_mem [PAGE_WORDS];
  logic [15:0]               fbuf_data_reg;
  logic                      sys_rst_n;
  logic                      por_rst_n;
  logic [1:0]                s_lock;
  logic [7:0]                s_fuse_low;
  logic [7:0]                s_fuse_high;
  logic [7:0]                s_fuse_ext;
  logic                      eep_busy;
  logic                      apb_setup;
  logic                      addr_hit;
  logic                      sw_wr;
  logic [`SPF_CTRL_W-1:0]    wr_code;
  logic                      arm;
  logic                      op_idle;
  logic                      store_take;
  logic                      load_take;
  logic                      start_op;
  logic                      op_done;
  logic                      buf_clear;
  logic [7:0]                cfg_byte;
  // Lower five bits must carry one of the arming codes
  function automatic logic legal_code(input logic [`SPF_CTRL_W-1:0] code);
    return code == `SPF_CODE_FILL || code == `SPF_CODE_ERASE || code == `SPF_CODE_WRITE ||
           code == `SPF_CODE_RDCFG || code == `SPF_CODE_CLRBUF;
  endfunction
  // Config byte picked by the two low pointer bits
  function automatic logic [7:0] cfg_pick(input logic [1:0] sel, input logic [1:0] lock,
                                          input logic [7:0] flo, input logic [7:0] fhi,
                                          input logic [7:0] fext);
    logic [7:0] r;
    unique case (sel)
      `SPF_CFG_FUSE_LOW:  r = flo;
      `SPF_CFG_LOCK:      r = {`SPF_LOCK_UNUSED, lock};
      `SPF_CFG_FUSE_EXT:  r = fext;
      `SPF_CFG_FUSE_HIGH: r = fhi;
    endcase
    return r;
  endfunction

  // Reset synchronisers; the power reset guards the flash timer and the page buffer
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else if (CE) begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  always_ff @(posedge CLK or negedge PWR_RESET_N) begin
    if (!PWR_RESET_N) begin
      por_meta_reg <= 1'b0;
      por_n_reg    <= 1'b0;
    end else if (CE) begin
      por_meta_reg <= 1'b1;
      por_n_reg    <= por_meta_reg;
    end
  end

  assign sys_rst_n = rst_n_reg;
  assign por_rst_n = por_n_reg;

  // Fuse, lock and EEPROM status come from outside the clock domain
  always_ff @(posedge CLK or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      pin_meta_reg <= `SPF_PIN_RESET;
      pin_reg      <= `SPF_PIN_RESET;
      eep_prev_reg <= 1'b1;
    end else if (CE) begin
      pin_meta_reg <= {EEPROM_WRITE_BUSY, FUSE_EXT, FUSE_HIGH, FUSE_LOW, LOCK_BITS};
      pin_reg      <= pin_meta_reg;
      eep_prev_reg <= pin_reg[26];
    end
  end

  // Values pass through unchanged: programmed reads zero
  assign s_lock      = pin_reg[1:0];
  assign s_fuse_low  = pin_reg[9:2];
  assign s_fuse_high = pin_reg[17:10];
  assign s_fuse_ext  = pin_reg[25:18];
  assign eep_busy    = pin_reg[26];

  // APB slave: one wait-free access phase, answer registered at setup
  assign apb_setup = PSEL && !PENABLE;
  assign addr_hit  = PADDR == `SPF_CTRL_ADDR;
  assign sw_wr     = PSEL && PENABLE && PWRITE && pready_reg && addr_hit && PSTRB[0];
  assign wr_code   = PWDATA[`SPF_CTRL_W-1:0];

  always_ff @(posedge CLK or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (CE) begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup && !addr_hit;
      prdata_reg  <= (apb_setup && !PWRITE && addr_hit) ? {27'h0000000, ctrl_reg} : 32'h0000_0000;
    end
  end

  // Arming is refused while EEPROM writes or a flash operation runs
  assign op_idle    = op_state_reg == SPF_OP_IDLE;
  assign arm        = sw_wr && legal_code(wr_code) && !eep_busy && op_idle;
  assign store_take = CORE_REQ.store && ctrl_reg[`SPF_BIT_STORE_EN] && op_idle && !eep_busy &&
                      elapsed_reg < `SPF_STORE_WIN;
  assign load_take  = CORE_REQ.load && ctrl_reg == `SPF_CODE_RDCFG && !eep_busy &&
                      elapsed_reg < `SPF_LOAD_WIN;
  assign start_op   = store_take && (ctrl_reg == `SPF_CODE_ERASE || ctrl_reg == `SPF_CODE_WRITE);
  assign op_done    = !op_idle && timer_reg == '0;

  // Command register; system reset clears it even mid-operation
  always_ff @(posedge CLK or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      ctrl_reg <= `SPF_CTRL_RESET;
    end else if (CE) begin
      if (arm) begin
        ctrl_reg <= wr_code;
      end else if (op_done) begin
        ctrl_reg <= `SPF_CTRL_RESET;
      end else if (store_take && !start_op) begin
        ctrl_reg <= `SPF_CTRL_RESET;
      end else if (load_take) begin
        ctrl_reg <= `SPF_CTRL_RESET;
      end else if (ctrl_reg == `SPF_CODE_RDCFG && elapsed_reg == `SPF_LOAD_WIN - 3'h1) begin
        ctrl_reg <= `SPF_CTRL_RESET;
      end else if (ctrl_reg[`SPF_BIT_STORE_EN] && op_idle && !start_op &&
                   elapsed_reg == `SPF_STORE_WIN - 3'h1) begin
        ctrl_reg <= `SPF_CTRL_RESET;
      end
    end
  end

  // Window counter starts with the clock after the register write
  always_ff @(posedge CLK or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      elapsed_reg <= 3'h0;
    end else if (CE) begin
      if (arm) begin
        elapsed_reg <= 3'h0;
      end else if (ctrl_reg[`SPF_BIT_STORE_EN] && elapsed_reg != 3'h7) begin
        elapsed_reg <= elapsed_reg + 3'h1;
      end
    end
  end

  // Flash timer sits on the power reset so a system reset cannot cut a write short
  always_ff @(posedge CLK or negedge por_rst_n) begin
    if (!por_rst_n) begin
      op_state_reg <= SPF_OP_IDLE;
      timer_reg    <= '0;
      op_ptr_reg   <= 16'h0000;
      stall_reg    <= 1'b0;
    end else if (CE) begin
      unique case (op_state_reg)
        SPF_OP_IDLE: begin
          if (start_op) begin
            op_state_reg <= (ctrl_reg == `SPF_CODE_ERASE) ? SPF_OP_ERASE : SPF_OP_WRITE;
            timer_reg    <= TIMW'(WRITE_CYCLES - 1);
            op_ptr_reg   <= CORE_REQ.pointer;
            stall_reg    <= 1'b1;
          end
        end
        SPF_OP_ERASE, SPF_OP_WRITE: begin
          if (op_done) begin
            op_state_reg <= SPF_OP_IDLE;
            stall_reg    <= 1'b0;
          end else begin
            timer_reg <= timer_reg - TIMW'(1);
          end
        end
        default: begin
          op_state_reg <= SPF_OP_IDLE;
          stall_reg    <= 1'b0;
        end
      endcase
    end
  end

  // An EEPROM write starting mid-fill loses the loaded data
  assign buf_clear = (arm && wr_code == `SPF_CODE_CLRBUF) ||
                     (op_done && op_state_reg == SPF_OP_WRITE) ||
                     (!sys_rst_n && op_idle) ||
                     (eep_busy && !eep_prev_reg);

  // Buffer held across a system reset that lands mid-write, cleared once idle
  always_ff @(posedge CLK or negedge por_rst_n) begin
    if (!por_rst_n) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        buf_mem[i] <= `SPF_BUF_ERASED;
      end
      fbuf_data_reg <= `SPF_BUF_ERASED;
    end else if (CE) begin
      if (buf_clear) begin
        for (int i = 0; i < PAGE_WORDS; i++) begin
          buf_mem[i] <= `SPF_BUF_ERASED;
        end
      end else if (store_take && ctrl_reg == `SPF_CODE_FILL) begin
        buf_mem[CORE_REQ.pointer[WB:1]] <= CORE_REQ.pair;
      end
      fbuf_data_reg <= buf_mem[FLASH_BUF_IDX];
    end
  end

  // Config read answer, one cycle after the load
  assign cfg_byte = cfg_pick(CORE_REQ.pointer[1:0], s_lock, s_fuse_low, s_fuse_high, s_fuse_ext);

  always_ff @(posedge CLK or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      load_valid_reg <= 1'b0;
      load_data_reg  <= 8'h00;
    end else if (CE) begin
      load_valid_reg <= load_take;
      load_data_reg  <= load_take ? cfg_byte : 8'h00;
    end
  end

  assign PRDATA         = prdata_reg;
  assign PREADY         = pready_reg;
  assign PSLVERR        = pslverr_reg;
  assign CORE_STALL     = stall_reg;
  assign LOAD_CFG_VALID = load_valid_reg;
  assign LOAD_CFG_DATA  = load_data_reg;
  assign FLASH_CMD      = '{op: op_state_reg, page_ptr: op_ptr_reg};
  assign FLASH_BUF_DATA = fbuf_data_reg;

  // Helper: length of each flash operation
  logic [TIMW:0] busy_cnt;
  always_ff @(posedge CLK or negedge por_rst_n) begin
    if (!por_rst_n) begin
      busy_cnt <= '0;
    end else if (CE) begin
      busy_cnt <= stall_reg ? busy_cnt + (TIMW+1)'(1) : '0;
    end
  end

  property p_cfg_load;
    @(posedge CLK) disable iff (!sys_rst_n || !CE)
    load_take |=> LOAD_CFG_VALID && LOAD_CFG_DATA == $past(cfg_byte);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config load not answered");

  property p_plain_load;
    @(posedge CLK) disable iff (!sys_rst_n || !CE)
    CORE_REQ.load && ctrl_reg != `SPF_CODE_RDCFG |=> !LOAD_CFG_VALID;
  endproperty
  a_plain_load: assert property (p_plain_load) else $error("plain load got config data");

  property p_rdcfg_timeout;
    @(posedge CLK) disable iff (!sys_rst_n || !CE)
    (arm && wr_code == `SPF_CODE_RDCFG) ##1 (!CORE_REQ.load && !arm)[*3] |=> ctrl_reg == `SPF_CTRL_RESET;
  endproperty
  a_rdcfg_timeout: assert property (p_rdcfg_timeout) else $error("config arming did not expire");

  property p_lock_bits;
    @(posedge CLK) disable iff (!sys_rst_n || !CE)
    load_take && CORE_REQ.pointer[1:0] == `SPF_CFG_LOCK |=> LOAD_CFG_DATA == {`SPF_LOCK_UNUSED, $past(s_lock)};
  endproperty
  a_lock_bits: assert property (p_lock_bits) else $error("lock byte layout wrong");

  property p_reserved;
    @(posedge CLK) disable iff (!sys_rst_n)
    PRDATA[31:5] == 27'h0000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_fill_timeout;
    @(posedge CLK) disable iff (!sys_rst_n || !CE)
    (arm && wr_code == `SPF_CODE_FILL) ##1 (!CORE_REQ.store && !arm)[*4] |=> ctrl_reg == `SPF_CTRL_RESET;
  endproperty
  a_fill_timeout: assert property (p_fill_timeout) else $error("store enable did not expire");

  property p_op_len;
    @(posedge CLK) disable iff (!por_rst_n || !CE)
    $fell(stall_reg) |-> busy_cnt == (TIMW+1)'(WRITE_CYCLES);
  endproperty
  a_op_len: assert property (p_op_len) else $error("flash operation length wrong");

  property p_stall;
    @(posedge CLK) disable iff (!por_rst_n || !CE)
    start_op |=> CORE_STALL && FLASH_CMD.op != SPF_OP_IDLE && FLASH_CMD.page_ptr == $past(CORE_REQ.pointer);
  endproperty
  a_stall: assert property (p_stall) else $error("operation did not start");

  property p_en_held;
    @(posedge CLK) disable iff (!sys_rst_n || !CE)
    start_op ##1 !op_done |-> ctrl_reg[`SPF_BIT_STORE_EN];
  endproperty
  a_en_held: assert property (p_en_held) else $error("store enable dropped mid operation");

  property p_illegal;
    @(posedge CLK) disable iff (!sys_rst_n || !CE)
    sw_wr && !legal_code(wr_code) && ctrl_reg == `SPF_CTRL_RESET |=> ctrl_reg == `SPF_CTRL_RESET;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal code armed");

  property p_clrbuf;
    @(posedge CLK) disable iff (!por_rst_n || !CE)
    arm && wr_code == `SPF_CODE_CLRBUF |=> buf_mem[0] == `SPF_BUF_ERASED;
  endproperty
  a_clrbuf: assert property (p_clrbuf) else $error("buffer not cleared");

  property p_eep_block;
    @(posedge CLK) disable iff (!sys_rst_n || !CE)
    eep_busy |=> !LOAD_CFG_VALID && !$rose(CORE_STALL);
  endproperty
  a_eep_block: assert property (p_eep_block) else $error("EEPROM busy did not block");

  c_fill:  cover property (@(posedge CLK) store_take && ctrl_reg == `SPF_CODE_FILL);
  c_erase: cover property (@(posedge CLK) start_op && ctrl_reg == `SPF_CODE_ERASE);
  c_write: cover property (@(posedge CLK) op_done && op_state_reg == SPF_OP_WRITE);
  c_cfg:   cover property (@(posedge CLK) load_take);

endmodule // spf_ctrl
`default_nettype wire

// [spf_core_model.sv]
// Processor core model issuing program store and load instructions
`timescale 1ns/100ps
`default_nettype none
module spf_core_model
  import spf_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          core_stall,
  output var  spf_core_req_s core_req
);
  initial core_req = '{store: 1'b0, load: 1'b0, pointer: 16'h5555, pair: 16'hAAAA};

  // Issue one instruction dly cycles after the call edge; a halted core waits
  task automatic issue(input logic ld, input int dly, input logic [15:0] ptr, input logic [15:0] pr);
    repeat (dly - 1) @(posedge clk);
    while (core_stall === 1'b1) @(posedge clk);
    core_req <= '{store: !ld, load: ld, pointer: ptr, pair: pr};
    @(posedge clk);
    // Request drops right after and operands are inverted, so stale values cannot pass
    core_req <= '{store: 1'b0, load: 1'b0, pointer: ~ptr, pair: ~pr};
  endtask
endmodule // spf_core_model
`default_nettype wire

// [spf_ctrl_bench.sv]
// Self-checking bench of the self-program flash control
`include "spf_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module spf_ctrl_bench;
  import spf_pkg::*;
  localparam int WC = 20;
  logic           clk, reset_n, pwr_reset_n, psel, penable, pwrite, pready, pslverr;
  logic           stall, cfg_valid, eeprom_busy, ce;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, seed, r;
  logic [7:0]     cfg_data, flo, fhi, fext, stall_n;
  logic [1:0]     lock;
  logic [2:0]     buf_idx;
  logic [15:0]    buf_data;
  logic [15:0]    words [8];
  logic [17:0]    op_s;
  spf_core_req_s  core_req;
  spf_flash_cmd_s flash_cmd;
  int             fails, n_tests, cycles;
  logic [33:0]    apb_q [$];
  logic [7:0]     cfg_q [$];
  logic [17:0]    op_q [$];

  spf_ctrl #(.PAGE_WORDS(8), .WRITE_CYCLES(WC)) u_spf_ctrl (
    .CLK(clk), .RESET_N(reset_n), .PWR_RESET_N(pwr_reset_n), .CE(ce),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CORE_REQ(core_req), .CORE_STALL(stall),
    .LOAD_CFG_VALID(cfg_valid), .LOAD_CFG_DATA(cfg_data), .LOCK_BITS(lock), .FUSE_LOW(flo),
    .FUSE_HIGH(fhi), .FUSE_EXT(fext), .EEPROM_WRITE_BUSY(eeprom_busy), .FLASH_CMD(flash_cmd),
    .FLASH_BUF_IDX(buf_idx), .FLASH_BUF_DATA(buf_data));
  spf_core_model u_spf_core_model (.clk(clk), .core_stall(stall), .core_req(core_req));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [33:0] g, input logic [33:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic cmp_apb(input logic [32:0] g, input logic [32:0] e);
    chk(34'(g), 34'(e), "register access");
  endtask
  task automatic cmp_cfg(input logic [8:0] g, input logic [8:0] e);
    chk(34'(g), 34'(e), "config load");
  endtask
  task automatic cmp_op(input logic [25:0] g, input logic [25:0] e);
    chk(34'(g), 34'(e), "flash operation");
  endtask
  task automatic cmp_buf(input logic [15:0] g, input logic [15:0] e);
    chk(34'(g), 34'(e), "page buffer word");
  endtask

  // Entry: check-data flag, error, data
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
    apb_q.push_back(e);
    // Idle edge first, so a release is never overwritten in the same step
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] v);
    apb(1'b1, `SPF_CTRL_ADDR, {24'h0, v}, 34'h0);
  endtask
  task automatic rd(input logic [4:0] v);
    apb(1'b0, `SPF_CTRL_ADDR, 32'h0, {2'b10, 27'h0, v});
  endtask
  task automatic buf_chk(input logic [2:0] i, input logic [15:0] e);
    buf_idx <= i;
    repeat (3) @(posedge clk);
    cmp_buf(buf_data, e);
  endtask
  task automatic cfg(input logic [1:0] sel, input int dly, input logic [7:0] e);
    wr(8'h09);
    if (dly < 4)
      cfg_q.push_back(e);
    u_spf_core_model.issue(1'b1, dly, {14'h0, sel}, 16'h1234);
    repeat (2) @(posedge clk);
    rd(5'h00);
  endtask
  task automatic fill(input logic [2:0] i);
    r = rnd();
    words[i] = r[15:0];
    wr(8'h01);
    u_spf_core_model.issue(1'b0, 1 + int'(r[17:16]), {12'h0, i, r[18]}, r[15:0]);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  always @(posedge clk) begin : mon_apb
    logic [33:0] e;
    if (psel && penable && pready === 1'b1) begin
      e = apb_q.pop_front();
      if (e[33])
        cmp_apb({pslverr, prdata}, e[32:0]);
      else
        cmp_apb({pslverr, 32'h0}, {e[32], 32'h0});
    end
    if (cfg_valid !== 1'b0)
      cmp_cfg({1'b0, cfg_data}, cfg_q.size() != 0 ? {1'b0, cfg_q.pop_front()} : 9'h100);
    if (!pwr_reset_n)
      stall_n = 8'h00;
    else if (stall === 1'b1) begin
      stall_n++;
      op_s = {flash_cmd.op, flash_cmd.page_ptr};
    end else if (stall_n != 8'h00) begin
      cmp_op({stall_n, op_s}, {8'(WC), op_q.size() != 0 ? op_q.pop_front() : 18'h0});
      stall_n = 8'h00;
    end
  end

  initial begin
    seed = 32'hCCAFEC90;
    {reset_n, pwr_reset_n, psel, penable, pwrite, eeprom_busy} = 6'h00;
    ce = 1'b1;
    {paddr, pwdata, buf_idx, lock} = '0;
    {flo, fhi, fext} = 24'hFFFFFF;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    pwr_reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int s = 0; s < 4; s++) begin
      r = rnd();
      {lock, fext, fhi, flo} <= r[25:0];
      repeat (4) @(posedge clk);
      cfg(2'(s), 1 + s % 3, s == 0 ? r[7:0] : s == 1 ? {6'h3F, r[25:24]} : s == 2 ? r[23:16] : r[15:8]);
    end
    cfg(2'd1, 4, 8'h00);
    apb(1'b0, 12'h0E0, 32'h0, {2'b01, 32'h0});
    foreach (words[k]) begin
      wr(8'h1F - 8'(k));
      u_spf_core_model.issue(1'b0, 1, 16'h0100, 16'h0);
      rd(5'h00);
    end
    wr(8'hE1);
    rd(5'h01);
    repeat (4) @(posedge clk);
    rd(5'h00);
    for (int i = 0; i < 8; i++)
      fill(3'(i));
    for (int i = 0; i < 8; i++)
      buf_chk(3'(i), words[i]);
    op_q.push_back({SPF_OP_WRITE, 16'h0140});
    wr(8'h05);
    u_spf_core_model.issue(1'b0, 4, 16'h0140, 16'h0F0F);
    repeat (WC + 4) @(posedge clk);
    rd(5'h00);
    buf_chk(3'd3, 16'hFFFF);
    fill(3'd2);
    buf_chk(3'd2, words[2]);
    wr(8'h11);
    buf_chk(3'd2, 16'hFFFF);
    // Clock enable low freezes the arming window
    wr(8'h01);
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    ce <= 1'b1;
    u_spf_core_model.issue(1'b0, 4, 16'h000A, r[31:16]);
    buf_chk(3'd5, r[31:16]);
    op_q.push_back({SPF_OP_ERASE, 16'h0280});
    wr(8'h03);
    u_spf_core_model.issue(1'b0, 1, 16'h0280, 16'h5A5A);
    rd(5'h03);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (WC + 3) @(posedge clk);
    rd(5'h00);
    wr(8'h03);
    u_spf_core_model.issue(1'b0, 5, 16'h0280, 16'h0);
    rd(5'h00);
    repeat (WC) @(posedge clk);
    eeprom_busy <= 1'b1;
    repeat (4) @(posedge clk);
    wr(8'h09);
    rd(5'h00);
    u_spf_core_model.issue(1'b1, 1, 16'h0001, 16'h0);
    eeprom_busy <= 1'b0;
    repeat (6) @(posedge clk);
    conclude();
  end
endmodule // spf_ctrl_bench
`default_nettype wire
